// >>> rtl/liu_ctrl_pkg.sv
// constants and types shared by the host port and interrupt logic
package liu_ctrl_pkg;

    // ==========================================================
    // widths and types
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int OFF_W  = 5;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] byte_t;
    typedef logic [OFF_W-1:0]  off_t;

    // ==========================================================
    // host port type selection
    localparam logic [1:0] MODE_HW     = 2'h0;
    localparam logic [1:0] MODE_SERIAL = 2'h1;
    localparam logic [1:0] MODE_PAR_A  = 2'h2;
    localparam logic [1:0] MODE_PAR_B  = 2'h3;

    // ==========================================================
    // global register map
    localparam addr_t ADDR_REVISION = 6'h00;
    localparam addr_t ADDR_SWRST    = 6'h01;
    localparam addr_t ADDR_GCF      = 6'h20;
    localparam addr_t ADDR_CHFLAGS  = 6'h21;
    localparam int    CHAN_BIT      = 5;

    // global_config fields
    localparam int    GCF_MON_HI   = 7;
    localparam int    GCF_MON_LO   = 6;
    localparam int    GCF_BCAST    = 3;
    localparam int    GCF_GMASK    = 2;
    localparam int    GCF_STYLE_HI = 1;
    localparam int    GCF_STYLE_LO = 0;
    localparam byte_t GCF_RESET    = 8'h00;
    localparam byte_t GCF_WMASK    = 8'hCF;

    // interrupt pin styles
    localparam logic [1:0] STYLE_PP_LOW  = 2'h1;
    localparam logic [1:0] STYLE_PP_HIGH = 2'h2;

    // ==========================================================
    // per-channel local register offsets
    localparam off_t LOC_FIRST   = 5'h02;
    localparam off_t LOC_LAST    = 5'h1B;
    localparam off_t LOC_MASK_A  = 5'h13;
    localparam off_t LOC_MASK_B  = 5'h14;
    localparam off_t LOC_EDGE    = 5'h15;
    localparam off_t LOC_STAT_A  = 5'h16;
    localparam off_t LOC_LATCH_A = 5'h18;
    localparam off_t LOC_LATCH_B = 5'h19;
    localparam byte_t MASK_RESET = 8'hFF;
    localparam byte_t EDGE_RESET = 8'h00;

    // ==========================================================
    // serial frame layout
    localparam int         SER_RW_BIT    = 0;
    localparam int         SER_ADDR_LO   = 1;
    localparam int         SER_ADDR_HI   = 6;
    localparam logic [4:0] SER_CMD_LAST  = 5'h07;
    localparam logic [4:0] SER_WORD_LAST = 5'h0F;

    typedef enum logic [3:0] {
        SER_IDLE = 4'h1,
        SER_CMD  = 4'h2,
        SER_RD   = 4'h4,
        SER_WR   = 4'h8
    } ser_phase_e;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SWRST_MAX_NS  = 1000;
    localparam int SWRST_CYC     = SWRST_MAX_NS / CLK_PERIOD_NS;
    localparam int HWRST_MIN_NS  = 100;
    localparam int HWRST_CYC     = (HWRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> rtl/chan_irq.sv
// per-channel event latches, masks, edge selection and local register reads
`timescale 1ns/1ns
`default_nettype none

module chan_irq #(
    parameter int N_STAT = 5,
    parameter int N_EVT  = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 swRst,
    input  wire logic [N_STAT-1:0]    statusIn,
    input  wire logic [N_EVT-1:0]     eventIn,
    input  wire logic                 wrEn,
    input  wire liu_ctrl_pkg::off_t   wrOff,
    input  wire liu_ctrl_pkg::byte_t  wrData,
    input  wire liu_ctrl_pkg::off_t   rdOff,
    input  wire logic                 clrA,
    input  wire logic                 clrB,
    output liu_ctrl_pkg::byte_t       rdData,
    output logic                      pending
);
    import liu_ctrl_pkg::*;

    if (N_STAT < 1 || N_STAT > DATA_W || N_EVT < 1 || N_EVT > DATA_W) begin : g_chk
        $error("chan_irq: event counts must fit one register");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [N_STAT-1:0] maskA;
        logic [N_EVT-1:0]  maskB;
        logic [N_STAT-1:0] edgeSel;
        logic [N_STAT-1:0] latchA;
        logic [N_EVT-1:0]  latchB;
        logic [N_STAT-1:0] statPrev;
    } chan_s;

    localparam chan_s RESET_S = '{
        maskA:    MASK_RESET[N_STAT-1:0],
        maskB:    MASK_RESET[N_EVT-1:0],
        edgeSel:  EDGE_RESET[N_STAT-1:0],
        latchA:   '0,
        latchB:   '0,
        statPrev: '0
    };

    chan_s             s_r;
    chan_s             s_nxt;
    logic [N_STAT-1:0] setA;

    always_comb begin
        s_nxt = s_r;
        setA = '0;
        for (int k = 0; k < N_STAT; k++) begin
            setA[k] = s_r.edgeSel[k] ? (statusIn[k] ^ s_r.statPrev[k]) : (statusIn[k] & ~s_r.statPrev[k]);
        end
        s_nxt.statPrev = statusIn;
        s_nxt.latchA = (s_r.latchA & ~{N_STAT{clrA}}) | setA;
        s_nxt.latchB = (s_r.latchB & ~{N_EVT{clrB}}) | eventIn;
        if (wrEn) begin
            case (wrOff)
                LOC_MASK_A: s_nxt.maskA   = wrData[N_STAT-1:0];
                LOC_MASK_B: s_nxt.maskB   = wrData[N_EVT-1:0];
                LOC_EDGE:   s_nxt.edgeSel = wrData[N_STAT-1:0];
                default:    s_nxt.maskA   = s_r.maskA;
            endcase
        end
        if (swRst) begin
            s_nxt = RESET_S;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= RESET_S;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // read data and pending
    always_comb begin
        case (rdOff)
            LOC_MASK_A:  rdData = byte_t'(s_r.maskA);
            LOC_MASK_B:  rdData = byte_t'(s_r.maskB);
            LOC_EDGE:    rdData = byte_t'(s_r.edgeSel);
            LOC_STAT_A:  rdData = byte_t'(statusIn);
            LOC_LATCH_A: rdData = byte_t'(s_r.latchA);
            LOC_LATCH_B: rdData = byte_t'(s_r.latchB);
            default:     rdData = '0;
        endcase
    end

    assign pending = |(s_r.latchA & ~s_r.maskA) | |(s_r.latchB & ~s_r.maskB);

    // ==========================================================
    // checks
    edge_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|setA && !swRst) |=> ((s_r.latchA & $past(setA)) == $past(setA)))
        else $error("selected status edge not latched");

    read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clrA && !swRst) |=> ((s_r.latchA & ~$past(setA)) == '0))
        else $error("latch read did not clear");

    event_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|eventIn && !swRst) ##1 (!clrB && !swRst) [*2] |-> ((s_r.latchB & $past(eventIn, 2)) == $past(eventIn, 2)))
        else $error("event latch lost without read");

endmodule

`default_nettype wire

// >>> rtl/host_port_irq.sv
// host port (serial and parallel), global registers and interrupt pin
`timescale 1ns/1ns
`default_nettype none

// Operation
// - mode pins pick serial 01, parallel style A 10, style B 11.
// - serial access is one 16-bit word: command byte then data byte.
// - direction 1 drives read data out; 0 takes write data in.
// - style 00 or 11 makes the interrupt pin open-drain active low.
// - style 01 push-pull active low, style 10 push-pull active high.
// - global mask bit suppresses all interrupts on the pin.
// - each event has its own latch bit and own mask bit.
// - edge select bit picks which status transition sets the latch.
// - reading a channel's latch registers clears its indicator bit.
// - pin inactive only when all channels acknowledged; each indicator clears when its own channel is.
// - each channel has thirteen event sources.
// - five status-backed events; others latch and mask only, overflow/underflow split.
// - any write to reset register resets device within one microsecond.
// - reset pin low at least 100 ns resets the device.
// - after reset drivers high impedance and registers at defaults.
// - global writes affect both channels; local writes only the addressed one.
// - broadcast bit copies local writes to the other channel.
// - global map: revision 00, reset 01, config 20, indicators 21.
// - a latch bit clears when its latch register is read.
module host_port_irq #(
    parameter liu_ctrl_pkg::byte_t REVISION = 8'h5A  // arbitrary value
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [1:0]           modeSel,
    input  wire logic                 chipSelN,
    input  wire logic                 serialClk,
    input  wire logic                 serialDataIn,
    output logic                      serialDataOut,
    output logic                      serialDataOutOeN,
    input  wire liu_ctrl_pkg::addr_t  parAddr,
    input  wire liu_ctrl_pkg::byte_t  parDataIn,
    output liu_ctrl_pkg::byte_t       parDataOut,
    output logic                      parDataOeN,
    input  wire logic                 readWriteSel,
    input  wire logic                 dataStrobeN,
    input  wire logic                 readStrobeN,
    input  wire logic                 writeStrobeN,
    input  wire logic [4:0]           ch1Status,
    input  wire logic [7:0]           ch1Events,
    input  wire logic [4:0]           ch2Status,
    input  wire logic [7:0]           ch2Events,
    output logic                      irqOut,
    output logic                      irqOeN,
    output logic [1:0]                monitorSel,
    output logic                      softResetPulse
);
    import liu_ctrl_pkg::*;

    localparam int NUM_CH     = 2;
    localparam int SwrstBound = SWRST_CYC;

    // ==========================================================
    // state
    typedef struct packed {
        ser_phase_e phase;
        logic [4:0] bitCnt;
        byte_t      cmd;
        byte_t      shiftReg;
        logic       sclkPrev;
        logic       strobePrev;
        byte_t      global_config;
        logic       sdoOut;
        logic       sdoOeN;
        byte_t      parOut;
        logic       parOeN;
        logic       irqOut;
        logic       irqOeN;
        logic       swRst;
    } port_s;

    localparam port_s RESET_S = '{
        phase:      SER_IDLE,
        bitCnt:     '0,
        cmd:        '0,
        shiftReg:   '0,
        sclkPrev:   1'b0,
        strobePrev: 1'b0,
        global_config:        GCF_RESET,
        sdoOut:     1'b0,
        sdoOeN:     1'b1,
        parOut:     '0,
        parOeN:     1'b1,
        irqOut:     1'b0,
        irqOeN:     1'b1,
        swRst:      1'b0
    };

    port_s              s_r;
    port_s              s_nxt;
    byte_t              cmdNew;
    byte_t              serDataNew;
    addr_t              rdAddr;
    byte_t              rdData;
    byte_t              chRd [NUM_CH];
    logic [NUM_CH-1:0]  pend;
    logic [NUM_CH-1:0]  locWrEn;
    logic [NUM_CH-1:0]  clrA;
    logic [NUM_CH-1:0]  clrB;
    logic               serialMode;
    logic               parMode;
    logic               serStep;
    logic               strobe;
    logic               parRead;
    logic               acc;
    logic               accRd;
    addr_t              accAddr;
    byte_t              accData;
    off_t               accOff;
    logic               isLocal;
    logic               wr;
    logic               swWrite;
    logic               irqAct;
    logic               pinIdle;

    // ==========================================================
    // port decode
    // port type from mode pins
    assign serialMode = (modeSel == MODE_SERIAL);
    assign parMode    = (modeSel == MODE_PAR_A) || (modeSel == MODE_PAR_B);
    assign serStep    = serialMode && !chipSelN && serialClk && !s_r.sclkPrev;
    assign cmdNew     = {serialDataIn, s_r.cmd[DATA_W-1:1]};
    assign serDataNew = {serialDataIn, s_r.shiftReg[DATA_W-1:1]};
    assign strobe     = !chipSelN && ((modeSel == MODE_PAR_A) ? !dataStrobeN : (!readStrobeN || !writeStrobeN));
    assign parRead    = (modeSel == MODE_PAR_A) ? readWriteSel : !readStrobeN;
    assign rdAddr     = serialMode ? cmdNew[SER_ADDR_HI:SER_ADDR_LO] : parAddr;

    // ==========================================================
    // read data
    always_comb begin
        case (rdAddr)
            ADDR_REVISION: rdData = REVISION;
            ADDR_GCF:      rdData = s_r.global_config;
            ADDR_CHFLAGS:  rdData = byte_t'(pend);
            default: begin
                if (rdAddr[OFF_W-1:0] >= LOC_FIRST && rdAddr[OFF_W-1:0] <= LOC_LAST) begin
                    rdData = chRd[rdAddr[CHAN_BIT]];
                end else begin
                    rdData = '0;
                end
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.swRst = 1'b0;
        acc = 1'b0;
        accRd = 1'b0;
        accAddr = s_r.cmd[SER_ADDR_HI:SER_ADDR_LO];
        accData = serDataNew;
        s_nxt.sclkPrev = serialClk;
        s_nxt.strobePrev = strobe;
        case (s_r.phase)
            SER_IDLE: begin
                s_nxt.bitCnt = '0;
                if (serialMode && !chipSelN) begin
                    s_nxt.phase = SER_CMD;
                end
            end
            SER_CMD: begin
                if (serStep) begin
                    s_nxt.cmd = cmdNew;
                    s_nxt.bitCnt = s_r.bitCnt + 5'h01;
                    if (s_r.bitCnt == SER_CMD_LAST) begin
                        if (cmdNew[SER_RW_BIT]) begin
                            acc = 1'b1;
                            accRd = 1'b1;
                            accAddr = cmdNew[SER_ADDR_HI:SER_ADDR_LO];
                            s_nxt.shiftReg = rdData;
                            s_nxt.sdoOut = rdData[0];
                            s_nxt.sdoOeN = 1'b0;
                            s_nxt.phase = SER_RD;
                        end else begin
                            s_nxt.phase = SER_WR;
                        end
                    end
                end
            end
            SER_RD: begin
                if (serStep) begin
                    s_nxt.shiftReg = {1'b0, s_r.shiftReg[DATA_W-1:1]};
                    s_nxt.sdoOut = s_r.shiftReg[1];
                end
            end
            SER_WR: begin
                if (serStep) begin
                    s_nxt.shiftReg = serDataNew;
                    s_nxt.bitCnt = s_r.bitCnt + 5'h01;
                    if (s_r.bitCnt == SER_WORD_LAST) begin
                        acc = 1'b1;
                        s_nxt.bitCnt = '0;
                        s_nxt.phase = SER_CMD;
                    end
                end
            end
            default: s_nxt.phase = SER_IDLE;
        endcase
        if (!serialMode || chipSelN) begin
            s_nxt.phase = SER_IDLE;
            s_nxt.sdoOeN = 1'b1;
        end
        // parallel access on strobe assertion
        if (parMode && strobe && !s_r.strobePrev) begin
            acc = 1'b1;
            accRd = parRead;
            accAddr = parAddr;
            accData = parDataIn;
            if (parRead) begin
                s_nxt.parOut = rdData;
            end
        end
        s_nxt.parOeN = !(parMode && strobe && parRead);
        // register decode
        accOff = accAddr[OFF_W-1:0];
        isLocal = (accOff >= LOC_FIRST) && (accOff <= LOC_LAST);
        wr = acc && !accRd;
        swWrite = wr && (accAddr == ADDR_SWRST);
        if (swWrite) begin
            s_nxt.swRst = 1'b1;
        end
        if (wr && accAddr == ADDR_GCF) begin
            s_nxt.global_config = accData & GCF_WMASK;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            locWrEn[i] = wr && isLocal && ((accAddr[CHAN_BIT] == i[0]) || s_r.global_config[GCF_BCAST]);
            clrA[i] = acc && accRd && isLocal && (accAddr[CHAN_BIT] == i[0]) && (accOff == LOC_LATCH_A);
            clrB[i] = acc && accRd && isLocal && (accAddr[CHAN_BIT] == i[0]) && (accOff == LOC_LATCH_B);
        end
        irqAct = !s_r.global_config[GCF_GMASK] && (|pend);
        case (s_r.global_config[GCF_STYLE_HI:GCF_STYLE_LO])
            STYLE_PP_LOW: begin
                s_nxt.irqOut = !irqAct;
                s_nxt.irqOeN = 1'b0;
            end
            STYLE_PP_HIGH: begin
                s_nxt.irqOut = irqAct;
                s_nxt.irqOeN = 1'b0;
            end
            default: begin
                s_nxt.irqOut = 1'b0;
                s_nxt.irqOeN = !irqAct;
            end
        endcase
        if (s_r.swRst) begin
            s_nxt.global_config = GCF_RESET;
            s_nxt.irqOut = RESET_S.irqOut;
            s_nxt.irqOeN = RESET_S.irqOeN;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= RESET_S;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // channels
    // thirteen sources per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        chan_irq #(
            .N_STAT (5),
            .N_EVT  (8)
        ) u_chan (
            .clk      (clk),
            .rst_n    (rst_n),
            .swRst    (s_r.swRst),
            .statusIn ((g == 0) ? ch1Status : ch2Status),
            .eventIn  ((g == 0) ? ch1Events : ch2Events),
            .wrEn     (locWrEn[g]),
            .wrOff    (accOff),
            .wrData   (accData),
            .rdOff    (rdAddr[OFF_W-1:0]),
            .clrA     (clrA[g]),
            .clrB     (clrB[g]),
            .rdData   (chRd[g]),
            .pending  (pend[g])
        );
    end

    // ==========================================================
    // outputs
    assign serialDataOut    = s_r.sdoOut;
    assign serialDataOutOeN = s_r.sdoOeN;
    assign parDataOut       = s_r.parOut;
    assign parDataOeN       = s_r.parOeN;
    assign irqOut           = s_r.irqOut;
    assign irqOeN           = s_r.irqOeN;
    assign monitorSel       = s_r.global_config[GCF_MON_HI:GCF_MON_LO];
    assign softResetPulse   = s_r.swRst;

    assign pinIdle = (s_r.global_config[GCF_STYLE_HI:GCF_STYLE_LO] == STYLE_PP_LOW)  ? (irqOut && !irqOeN) :
                     (s_r.global_config[GCF_STYLE_HI:GCF_STYLE_LO] == STYLE_PP_HIGH) ? (!irqOut && !irqOeN) : irqOeN;

    // ==========================================================
    // checks
    serial_mode_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!serialMode) |=> serialDataOutOeN)
        else $error("serial output driven outside serial mode");

    ser_read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == SER_CMD && serStep && s_r.bitCnt == SER_CMD_LAST && cmdNew[SER_RW_BIT])
        |=> (!serialDataOutOeN && serialDataOut == $past(rdData[0])))
        else $error("serial read data not driven");

    ser_write_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == SER_WR && serStep && s_r.bitCnt == SER_WORD_LAST
         && s_r.cmd[SER_ADDR_HI:SER_ADDR_LO] == ADDR_GCF && !s_r.swRst)
        |=> (s_r.global_config == ($past(serDataNew) & GCF_WMASK)))
        else $error("serial write not applied");

    open_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!s_r.global_config[GCF_STYLE_LO] && s_r.global_config[GCF_STYLE_HI:GCF_STYLE_LO] != STYLE_PP_HIGH && !s_r.swRst)
        |=> (!irqOut && irqOeN == !$past(irqAct)))
        else $error("open-drain pin misbehaves");

    push_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.global_config[GCF_STYLE_HI:GCF_STYLE_LO] == STYLE_PP_HIGH && !s_r.swRst)
        |=> (!irqOeN && irqOut == $past(irqAct)))
        else $error("push-pull high pin misbehaves");

    global_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.global_config[GCF_GMASK] && $stable(s_r.global_config) && !$past(s_r.swRst)) |-> pinIdle)
        else $error("masked interrupt reached pin");

    broadcast_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && isLocal && s_r.global_config[GCF_BCAST]) |-> (locWrEn == 2'h3))
        else $error("broadcast write not copied");

    local_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr && isLocal && !s_r.global_config[GCF_BCAST]) |-> (locWrEn == (accAddr[CHAN_BIT] ? 2'h2 : 2'h1)))
        else $error("local write reached wrong channel");

    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        swWrite |-> ##[1:SwrstBound] (s_r.global_config == GCF_RESET))
        else $error("soft reset too slow");

endmodule

`default_nettype wire

// >>> tb/irq_pullup.sv
// host side pull-up resistor on the interrupt line
`timescale 1ns/1ns
`default_nettype none
module irq_pullup (
    input  wire logic irqOut,
    input  wire logic irqOeN,
    output logic      irqLine
);
    assign irqLine = irqOeN ? 1'b1 : irqOut;
endmodule
`default_nettype wire

// >>> tb/host_port_irq_tb.sv
// register access and interrupt tests for the host port
`timescale 1ns/1ns
`default_nettype none
module host_port_irq_tb;
    import liu_ctrl_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       rdN = 1'b1;
    logic       wrN = 1'b1;
    logic       csN = 1'b1;
    addr_t      adr = '0;
    byte_t      din = '0;
    byte_t      dout;
    logic [4:0] st = '0;
    logic [1:0] mode = 2'h3;
    logic       sclk = 1'b0;
    logic       serial_data_in = 1'b0;
    logic       serial_data_out;
    logic       sdoE;
    byte_t      ev = '0;
    logic [1:0] mon;
    logic       srst;
    byte_t      sq;
    logic       oeN;
    logic       irqO;
    logic       irqE;
    logic       irqLine;
    int         failCount = 0;
    int         testsRun = 0;

    host_port_irq dut (.clk(clk), .rst_n(rst_n), .modeSel(mode), .chipSelN(csN),
        .serialClk(sclk), .serialDataIn(serial_data_in), .serialDataOut(serial_data_out), .serialDataOutOeN(sdoE),
        .parAddr(adr), .parDataIn(din), .parDataOut(dout), .parDataOeN(oeN),
        .readWriteSel(1'b1), .dataStrobeN(1'b1), .readStrobeN(rdN), .writeStrobeN(wrN),
        .ch1Status(st), .ch1Events(ev), .ch2Status(st), .ch2Events(ev),
        .irqOut(irqO), .irqOeN(irqE), .monitorSel(mon), .softResetPulse(srst));
    irq_pullup host (.irqOut(irqO), .irqOeN(irqE), .irqLine(irqLine));

    initial begin
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // access tasks
    task automatic finalReport();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input byte_t seen, input byte_t exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input addr_t a, input byte_t d);
        @(posedge clk);
        adr <= a;
        din <= d;
        csN <= 1'b0;
        wrN <= 1'b0;
        @(posedge clk);
        wrN <= 1'b1;
        csN <= 1'b1;
    endtask
    task automatic rd(input addr_t a, input byte_t e);
        int n;
        @(posedge clk);
        adr <= a;
        csN <= 1'b0;
        rdN <= 1'b0;
        for (n = 0; n < 5; n++) begin
            @(posedge clk);
            #1;
            if (oeN === 1'b0) break;
        end
        if (n == 5) begin
            failCount++;
            finalReport();
        end
        chk(dout, e);
        @(posedge clk);
        rdN <= 1'b1;
        csN <= 1'b1;
    endtask
    task automatic pin(input logic e);
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irqLine}, {7'h00, e});
    endtask
    task automatic ser(input logic rw, input addr_t a, input byte_t d, output byte_t q);
        logic [15:0] w;
        w = {d, 1'b0, a, rw};
        q = '0;
        @(posedge clk);
        csN <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            serial_data_in <= w[i];
            @(posedge clk);
            if (i > 7) begin
                q[i-8] = serial_data_out;
            end
            if (i == 8) begin
                chk({7'h00, sdoE}, {7'h00, ~rw});
            end
            sclk <= 1'b1;
            @(posedge clk);
            sclk <= 1'b0;
        end
        @(posedge clk);
        csN <= 1'b1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_REVISION, 8'h5A);
        rd(ADDR_GCF, GCF_RESET);
        rd(ADDR_CHFLAGS, 8'h00);
        wr(ADDR_GCF, 8'h08);
        wr(6'h13, 8'h00);
        rd(6'h33, 8'h00);
        wr(ADDR_GCF, 8'h00);
        wr(6'h33, 8'h1E);
        rd(6'h13, 8'h00);
        rd(6'h33, 8'h1E);
        wr(6'h33, 8'h00);
        @(posedge clk);
        st <= 5'h01;
        pin(1'b0);
        rd(ADDR_CHFLAGS, 8'h03);
        wr(ADDR_GCF, 8'h04);
        pin(1'b1);
        wr(ADDR_GCF, 8'h01);
        pin(1'b0);
        wr(ADDR_GCF, 8'h02);
        pin(1'b1);
        rd(6'h18, 8'h01);
        rd(6'h18, 8'h00);
        rd(ADDR_CHFLAGS, 8'h02);
        pin(1'b1);
        rd(6'h38, 8'h01);
        rd(ADDR_CHFLAGS, 8'h00);
        pin(1'b0);
        @(posedge clk);
        ev <= 8'h02;
        @(posedge clk);
        ev <= 8'h00;
        rd(6'h19, 8'h02);
        rd(6'h19, 8'h00);
        rd(6'h39, 8'h02);
        wr(6'h15, 8'h01);
        @(posedge clk);
        st <= 5'h00;
        rd(6'h18, 8'h01);
        rd(6'h38, 8'h00);
        wr(ADDR_SWRST, 8'h00);
        #1;
        chk({7'h00, srst}, 8'h01);
        repeat (10) @(posedge clk);
        rd(ADDR_GCF, GCF_RESET);
        pin(1'b1);
        @(posedge clk);
        mode <= MODE_SERIAL;
        ser(1'b0, ADDR_GCF, 8'hC0, sq);
        ser(1'b1, ADDR_GCF, 8'h00, sq);
        chk(sq, 8'hC0);
        chk({6'h00, mon}, 8'h03);
        ser(1'b1, ADDR_REVISION, 8'h00, sq);
        chk(sq, 8'h5A);
        finalReport();
    end
endmodule
`default_nettype wire
